// File: logic/sfb_consts.svh
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH

// Array geometry
`define SFB_ADDR_W          18
`define SFB_ARRAY_BYTES     262144
`define SFB_PAGE_COUNT      1024
`define SFB_PAGE_BYTES      256
`define SFB_SECTOR_COUNT    64
`define SFB_BLOCK_COUNT     4
`define SFB_PAGE_LSB        8
`define SFB_SECTOR_LSB      12
`define SFB_BLOCK_LSB       16
`define SFB_SECTOR_BYTES    18'h01000
`define SFB_SECTOR_MASK     18'h00fff
`define SFB_BLOCK_MASK      18'h0ffff
`define SFB_LAST_SECTOR     18'h3f000
`define SFB_LAST_ADDR       18'h3ffff
`define SFB_FIRST_ADDR      18'h00000

// Protected areas
`define SFB_PROT_QUARTER    18'h30000
`define SFB_PROT_HALF       18'h20000

// Serial framing
`define SFB_BYTE_LAST_BIT   3'h7
`define SFB_PROG_MAX        9'h100

// Reset values
`define SFB_RST_BYTE        8'h00
`define SFB_RST_BITCNT      3'h0
`define SFB_RST_COUNT       9'h000

`endif

// File: logic/sfb_pkg.sv
`default_nettype none
package sfb_pkg;

  typedef enum logic [2:0] {
    SFB_IDLE  = 3'b001,
    SFB_SHIFT = 3'b010,
    SFB_HOLD  = 3'b100
  } sfb_frame_t;

  typedef enum logic [1:0] {
    SFB_ERASE_SECTOR = 2'h0,
    SFB_ERASE_BLOCK  = 2'h1,
    SFB_ERASE_CHIP   = 2'h2
  } sfb_erase_t;

  typedef struct packed {
    logic sck;
    logic select_n;
    logic pause_n;
    logic serial_in;
    logic write_guard_n;
  } sfb_pins_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } sfb_rx_t;

  typedef struct packed {
    sfb_pins_t   sync1;
    sfb_pins_t   sync2;
    logic        sck_d;
    logic        sel_d;
    sfb_frame_t  frame;
    logic        first_byte;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic        pend_valid;
    sfb_rx_t     pend;
    logic        rx_overrun;
    logic        rise_seen;
    logic [7:0]  tx_sh;
    logic        tx_active;
    logic        tx_take;
    logic        oe_saved;
    logic        serial_out;
    logic        serial_out_oe;
    logic        spi_mode3;
    logic        standby;
    logic        status_write_ok;
    logic        addr_protected;
    logic [9:0]  page_index;
    logic [5:0]  sector_index;
    logic [1:0]  block_index;
    logic [17:0] erase_lo;
    logic [17:0] erase_hi;
    logic        erase_valid;
    logic [7:0]  merged_byte;
    logic [8:0]  prog_count;
    logic        prog_room;
  } sfb_state_t;

endpackage : sfb_pkg
`default_nettype wire

// File: logic/sfb_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module sfb_buf2 #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  // Head drives the outputs straight from flops; tail absorbs one stall
  typedef struct packed {
    logic         hv;
    logic         tv;
    logic [W-1:0] h;
    logic [W-1:0] t;
  } sfb_buf_state_t;

  sfb_buf_state_t s;
  sfb_buf_state_t next_s;
  logic           push;
  logic           pop;

  assign in_ready  = !s.tv;
  assign out_valid = s.hv;
  assign out_data  = s.h;
  assign push      = in_valid && !s.tv;
  assign pop       = s.hv && out_ready;

  always_comb begin
    next_s = s;
    if (!s.hv || pop) begin
      if (s.tv) begin
        next_s.h  = s.t;
        next_s.hv = 1'b1;
        next_s.tv = push;
        next_s.t  = in_data;
      end else begin
        next_s.h  = in_data;
        next_s.hv = push;
      end
    end else if (push) begin
      next_s.t  = in_data;
      next_s.tv = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : sfb_buf2
`default_nettype wire

// File: logic/sfb_front_end.sv
// Functional notes
// - Sample serial_in bits on each rising serial clock edge.
// - Launch outgoing bits on serial_out at falling serial clock edges.
// - Select high means deselected, serial_out tri-stated.
// - Deselect does not stop a running internal cycle; standby only after.
// - Select low selects device; accept input bits, return output data.
// - Only a select high-to-low transition opens a frame; else ignore. Here a select held low through reset also opens one.
// - Pause low while selected tri-states output, ignores clock and data.
// - Write guard plus lock bit block status writes; protect levels guard array.
// - Array is 262144 bytes in 1024 pages of 256 bytes.
// - 64 sectors of 4 KB grouped in 4 blocks of 64 KB.
// - Programming only turns ones into zeros.
// - Erase by sector, block or chip; never by page.
// - Sector n starts at n times 1000h.
// - Page program accepts 1 to 256 bytes.
// - Only SPI mode 0 or mode 3 is used.
`timescale 1ns/100ps
`default_nettype none
`include "sfb_consts.svh"
module sfb_front_end
  import sfb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sck,
  input  wire logic        select_n,
  input  wire logic        pause_n,
  input  wire logic        serial_in,
  input  wire logic        write_guard_n,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic [7:0]       rx_byte,
  output logic             rx_first,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_overrun,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             spi_mode3,
  input  wire logic        cycle_busy,
  output logic             standby,
  input  wire logic        protect_level,
  input  wire logic        protect_level_mid,
  input  wire logic        protect_level_high,
  input  wire logic        status_lock_bit,
  output logic             status_write_ok,
  input  wire logic [17:0] op_addr,
  input  wire logic        op_start,
  input  wire sfb_erase_t  erase_kind,
  input  wire logic        prog_byte,
  input  wire logic [7:0]  old_byte,
  input  wire logic [7:0]  new_byte,
  output logic [7:0]       merged_byte,
  output logic [9:0]       page_index,
  output logic [5:0]       sector_index,
  output logic [1:0]       block_index,
  output logic             addr_protected,
  output logic [17:0]      erase_lo,
  output logic [17:0]      erase_hi,
  output logic             erase_valid,
  output logic [8:0]       prog_count,
  output logic             prog_room
);

  sfb_state_t s;
  sfb_state_t next_s;
  sfb_pins_t  p;
  sfb_rx_t    rx_head;
  logic       buf_in_ready;
  logic       rise;
  logic       fall;
  logic       sel_fall;
  logic [7:0] rx_full;

  // Only the second synchroniser stage is ever looked at
  assign p        = s.sync2;
  assign rise     = p.sck && !s.sck_d;
  assign fall     = !p.sck && s.sck_d;
  assign sel_fall = s.sel_d && !p.select_n;
  assign rx_full  = {s.rx_sh[6:0], p.serial_in};

  function automatic logic prot_hit(input logic [2:0] lvl, input logic [17:0] a);
    logic hit;
    hit = 1'b1;
    unique case (lvl)
      3'h0:    hit = 1'b0;
      3'h1:    hit = (a >= `SFB_PROT_QUARTER);
      3'h2:    hit = (a >= `SFB_PROT_HALF);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : prot_hit

  always_comb begin
    next_s         = s;
    next_s.sync1   = '{sck, select_n, pause_n, serial_in, write_guard_n};
    next_s.sync2   = s.sync1;
    next_s.sck_d   = p.sck;
    next_s.sel_d   = p.select_n;
    next_s.tx_take = 1'b0;

    if (s.pend_valid && buf_in_ready) begin
      next_s.pend_valid = 1'b0;
    end

    unique case (s.frame)
      SFB_IDLE: begin
        next_s.serial_out_oe = 1'b0;
        // A frame opens only on a seen select fall; reset loads select high, so a select held low through reset opens one
        if (sel_fall) begin
          next_s.frame      = SFB_SHIFT;
          next_s.bit_cnt    = `SFB_RST_BITCNT;
          next_s.first_byte = 1'b1;
          next_s.rise_seen  = 1'b0;
          next_s.tx_active  = 1'b0;
          next_s.spi_mode3  = p.sck;
        end
      end
      SFB_SHIFT: begin
        if (p.select_n) begin
          next_s.frame         = SFB_IDLE;
          next_s.serial_out_oe = 1'b0;
          next_s.tx_active     = 1'b0;
        end else if (!p.pause_n) begin
          next_s.frame         = SFB_HOLD;
          next_s.oe_saved      = s.serial_out_oe;
          next_s.serial_out_oe = 1'b0;
        end else begin
          if (rise) begin
            next_s.rx_sh     = rx_full;
            next_s.bit_cnt   = s.bit_cnt + 3'h1;
            next_s.rise_seen = 1'b1;
            if (s.bit_cnt == `SFB_BYTE_LAST_BIT) begin
              // No way to stall the host, so a fourth pending byte is flagged
              if (s.pend_valid && !buf_in_ready) begin
                next_s.rx_overrun = 1'b1;
              end else begin
                next_s.pend       = '{s.first_byte, rx_full};
                next_s.pend_valid = 1'b1;
              end
              next_s.first_byte = 1'b0;
              next_s.tx_active  = tx_valid;
              next_s.tx_take    = tx_valid;
              if (tx_valid) begin
                next_s.tx_sh = tx_byte;
              end
            end
          end
          // Mode 3 idles high, so the fall before the first rise is skipped
          if (fall && s.rise_seen && s.tx_active) begin
            next_s.serial_out    = s.tx_sh[7];
            next_s.tx_sh         = {s.tx_sh[6:0], 1'b0};
            next_s.serial_out_oe = 1'b1;
          end
        end
      end
      SFB_HOLD: begin
        next_s.serial_out_oe = 1'b0;
        if (p.select_n) begin
          next_s.frame     = SFB_IDLE;
          next_s.tx_active = 1'b0;
        end else if (p.pause_n) begin
          next_s.frame         = SFB_SHIFT;
          next_s.serial_out_oe = s.oe_saved;
        end
      end
      default: begin
        next_s.frame         = SFB_IDLE;
        next_s.serial_out_oe = 1'b0;
      end
    endcase

    // Busy cycle keeps the part active even when deselected
    next_s.standby         = p.select_n && !cycle_busy;
    next_s.status_write_ok = !(status_lock_bit && !p.write_guard_n);
    next_s.addr_protected  = prot_hit({protect_level_high, protect_level_mid,
                                       protect_level}, op_addr);

    next_s.page_index   = op_addr[`SFB_ADDR_W-1:`SFB_PAGE_LSB];
    next_s.sector_index = op_addr[`SFB_ADDR_W-1:`SFB_SECTOR_LSB];
    next_s.block_index  = op_addr[`SFB_ADDR_W-1:`SFB_BLOCK_LSB];
    next_s.merged_byte  = old_byte & new_byte;

    next_s.erase_valid = 1'b0;
    if (op_start) begin
      next_s.prog_count = `SFB_RST_COUNT;
      next_s.prog_room  = 1'b1;
      unique case (erase_kind)
        SFB_ERASE_SECTOR: begin
          next_s.erase_lo    = op_addr & ~`SFB_SECTOR_MASK;
          next_s.erase_hi    = op_addr | `SFB_SECTOR_MASK;
          next_s.erase_valid = 1'b1;
        end
        SFB_ERASE_BLOCK: begin
          next_s.erase_lo    = op_addr & ~`SFB_BLOCK_MASK;
          next_s.erase_hi    = op_addr | `SFB_BLOCK_MASK;
          next_s.erase_valid = 1'b1;
        end
        SFB_ERASE_CHIP: begin
          next_s.erase_lo    = `SFB_FIRST_ADDR;
          next_s.erase_hi    = `SFB_LAST_ADDR;
          next_s.erase_valid = 1'b1;
        end
        default: next_s.erase_valid = 1'b0;
      endcase
    end else if (prog_byte && s.prog_room) begin
      next_s.prog_count = s.prog_count + 9'h001;
      next_s.prog_room  = (s.prog_count + 9'h001) < `SFB_PROG_MAX;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s           <= '0;
      s.sync1     <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      s.sync2     <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      s.sel_d     <= 1'b1;
      s.frame     <= SFB_IDLE;
      s.standby   <= 1'b1;
      s.prog_room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  sfb_buf2 #(
    .W($bits(sfb_rx_t))
  ) u_rx_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .in_data  (s.pend),
    .in_valid (s.pend_valid),
    .in_ready (buf_in_ready),
    .out_data (rx_head),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign rx_byte         = rx_head.data;
  assign rx_first        = rx_head.first;
  assign rx_overrun      = s.rx_overrun;
  assign serial_out      = s.serial_out;
  assign serial_out_oe   = s.serial_out_oe;
  assign tx_ready        = s.tx_take;
  assign spi_mode3       = s.spi_mode3;
  assign standby         = s.standby;
  assign status_write_ok = s.status_write_ok;
  assign addr_protected  = s.addr_protected;
  assign page_index      = s.page_index;
  assign sector_index    = s.sector_index;
  assign block_index     = s.block_index;
  assign merged_byte     = s.merged_byte;
  assign erase_lo        = s.erase_lo;
  assign erase_hi        = s.erase_hi;
  assign erase_valid     = s.erase_valid;
  assign prog_count      = s.prog_count;
  assign prog_room       = s.prog_room;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seq_rise_in;
    s.frame == SFB_SHIFT && !p.select_n && p.pause_n && rise;
  endsequence

  sequence seq_fall_out;
    s.frame == SFB_SHIFT && !p.select_n && p.pause_n && fall && s.rise_seen && s.tx_active;
  endsequence

  deselect_tristate_a: assert property (p.select_n |=> !s.serial_out_oe)
    else $error("output driven while deselected");
  pause_tristate_a: assert property ((s.frame == SFB_HOLD && !p.pause_n) |=> !s.serial_out_oe)
    else $error("output driven while paused");
  rise_sample_a: assert property (seq_rise_in |=> s.rx_sh[0] == $past(p.serial_in))
    else $error("input bit not taken on rising edge");
  fall_launch_a: assert property (seq_fall_out |=> s.serial_out == $past(s.tx_sh[7]) && s.serial_out_oe)
    else $error("output bit not launched on falling edge");
  open_on_fall_a: assert property ((s.frame == SFB_IDLE && !sel_fall) |=> s.frame == SFB_IDLE)
    else $error("frame opened without select fall");
  busy_standby_a: assert property (cycle_busy |=> !s.standby)
    else $error("standby during internal cycle");
  hold_keeps_bits_a: assert property ((s.frame == SFB_HOLD) |=> s.bit_cnt == $past(s.bit_cnt) && s.rx_sh == $past(s.rx_sh))
    else $error("shift state lost during pause");
  guard_blocks_a: assert property ((status_lock_bit && !p.write_guard_n) |=> !s.status_write_ok)
    else $error("status write allowed under guard");
  one_to_zero_a: assert property (1'b1 |=> (s.merged_byte & ~$past(old_byte)) == 8'h00)
    else $error("programming raised a bit");
  erase_aligned_a: assert property (s.erase_valid |-> s.erase_lo[11:0] == 12'h000 && s.erase_hi[11:0] == 12'hfff)
    else $error("erase range not sector aligned");
  prog_cap_a: assert property (s.prog_count <= 9'h100)
    else $error("page program count past 256");

endmodule : sfb_front_end
`default_nettype wire

// File: testbench/sfb_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module sfb_spi_host #(
  parameter int HALF = 120
) (
  output logic      sck,
  output logic      select_n,
  output logic      pause_n,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic mode3;
  logic last_out;
  logic pause_oe;
  // Released line floats; show inverse of last driven bit so stale data never passes
  wire logic line_out = serial_out_oe ? serial_out : ~last_out;

  initial begin
    sck = 1'b0;
    select_n = 1'b1;
    pause_n = 1'b1;
    serial_in = 1'b0;
    mode3 = 1'b0;
    last_out = 1'b0;
    pause_oe = 1'b0;
  end

  always @(serial_out) begin
    if (serial_out_oe === 1'b1) begin
      last_out = serial_out;
    end
  end

  task open_frame(input logic m3);
    mode3 = m3;
    sck = m3;
    #HALF;
    select_n = 1'b0;
    #HALF;
  endtask : open_frame

  task close_frame();
    #HALF;
    select_n = 1'b1;
    #HALF;
  endtask : close_frame

  // Half period of six system clocks leaves room for the pin synchronisers
  task xfer(input logic [7:0] tx, input int nbits, input int pause_at, output logic [7:0] rx);
    rx = 8'h00;
    for (int k = 0; k < nbits; k++) begin
      sck = 1'b0;
      serial_in = tx[7-k];
      #HALF;
      sck = 1'b1;
      rx[7-k] = line_out;
      #HALF;
      if (k == pause_at) begin
        pause_n = 1'b0;
        #HALF;
        pause_oe = serial_out_oe;
        // Junk edges while paused must not count
        repeat (3) begin
          sck = ~sck;
          serial_in = ~serial_in;
          #HALF;
        end
        sck = 1'b1;
        #HALF;
        pause_n = 1'b1;
        #HALF;
      end
    end
    if (!mode3) begin
      sck = 1'b0;
    end
  endtask : xfer
endmodule : sfb_spi_host
`default_nettype wire

// File: testbench/serial_flash_bus_front_end_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; $display("FAIL at %0t got %h expected %h", $time, (a), (e)); end end
module serial_flash_bus_front_end_test
  import sfb_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sck, select_n, pause_n, serial_in, write_guard_n, serial_out, serial_out_oe;
  logic [7:0]  rx_byte, tx_byte, old_byte, new_byte, merged_byte, rxd;
  logic        rx_first, rx_valid, rx_ready, rx_overrun, tx_valid, tx_ready, spi_mode3;
  logic        cycle_busy, standby, status_lock_bit, status_write_ok, addr_protected;
  logic        protect_level, protect_level_mid, protect_level_high;
  logic        op_start, prog_byte, erase_valid, prog_room;
  logic [17:0] op_addr, erase_lo, erase_hi;
  sfb_erase_t  erase_kind;
  logic [9:0]  page_index;
  logic [5:0]  sector_index;
  logic [1:0]  block_index;
  logic [8:0]  prog_count;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          tx_takes = 0;
  sfb_rx_t     rxq[$];

  typedef struct {
    logic [17:0] addr;
    sfb_erase_t  kind;
    logic [2:0]  prot;
    logic [7:0]  old_b;
    logic [7:0]  new_b;
    logic [7:0]  merged;
    logic [17:0] lo;
    logic [17:0] hi;
    logic        ev;
    logic        pr;
  } sfb_row_t;
  sfb_row_t rows [5] = '{
    '{18'h3f123, SFB_ERASE_SECTOR, 3'h1, 8'hff, 8'h5a, 8'h5a, 18'h3f000, 18'h3ffff, 1'b1, 1'b1},
    '{18'h2abcd, SFB_ERASE_BLOCK, 3'h1, 8'h0f, 8'h3c, 8'h0c, 18'h20000, 18'h2ffff, 1'b1, 1'b0},
    '{18'h00fff, SFB_ERASE_CHIP, 3'h3, 8'ha5, 8'hff, 8'ha5, 18'h00000, 18'h3ffff, 1'b1, 1'b1},
    '{18'h1f000, sfb_erase_t'(2'h3), 3'h2, 8'h00, 8'hff, 8'h00, 18'h00000, 18'h00000, 1'b0, 1'b0},
    '{18'h20000, SFB_ERASE_SECTOR, 3'h2, 8'hf0, 8'h0f, 8'h00, 18'h20000, 18'h20fff, 1'b1, 1'b1}
  };

  sfb_front_end dut (.clk, .sys_rst, .sck, .select_n, .pause_n, .serial_in, .write_guard_n,
    .serial_out, .serial_out_oe, .rx_byte, .rx_first, .rx_valid, .rx_ready, .rx_overrun,
    .tx_byte, .tx_valid, .tx_ready, .spi_mode3, .cycle_busy, .standby, .protect_level,
    .protect_level_mid, .protect_level_high, .status_lock_bit, .status_write_ok, .op_addr,
    .op_start, .erase_kind, .prog_byte, .old_byte, .new_byte, .merged_byte, .page_index,
    .sector_index, .block_index, .addr_protected, .erase_lo, .erase_hi, .erase_valid,
    .prog_count, .prog_room);
  sfb_spi_host host (.sck, .select_n, .pause_n, .serial_in, .serial_out, .serial_out_oe);

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      rxq.push_back(sfb_rx_t'({rx_first, rx_byte}));
    end
    if (tx_ready === 1'b1) begin
      tx_takes++;
    end
  end

  task give_verdict();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs about 1300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic check_rx(input sfb_rx_t exp);
    sfb_rx_t got;
    got = '0;
    for (int n = 0; n < 40 && rxq.size() == 0; n++) @(posedge clk);
    if (rxq.size() != 0) got = rxq.pop_front();
    `CHK(got, exp)
  endtask : check_rx

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  initial begin
    write_guard_n = 1'b1;
    rx_ready = 1'b1;
    tx_byte = 8'ha5;
    tx_valid = 1'b1;
    cycle_busy = 1'b0;
    {protect_level_high, protect_level_mid, protect_level} = 3'h0;
    status_lock_bit = 1'b0;
    op_addr = 18'h00000;
    op_start = 1'b0;
    erase_kind = SFB_ERASE_SECTOR;
    prog_byte = 1'b0;
    old_byte = 8'h00;
    new_byte = 8'h00;
    settle(2);
    sys_rst = 1'b0;
    `CHK(serial_out_oe, 1'b0)
    `CHK(prog_room, 1'b1)
    foreach (rows[i]) begin
      settle(1);
      op_addr = rows[i].addr;
      erase_kind = rows[i].kind;
      {protect_level_high, protect_level_mid, protect_level} = rows[i].prot;
      old_byte = rows[i].old_b;
      new_byte = rows[i].new_b;
      op_start = 1'b1;
      settle(1);
      op_start = 1'b0;
      `CHK(erase_valid, rows[i].ev)
      if (rows[i].ev) begin
        `CHK(erase_lo, rows[i].lo)
        `CHK(erase_hi, rows[i].hi)
      end
      `CHK(merged_byte, rows[i].merged)
      `CHK(addr_protected, rows[i].pr)
      `CHK(page_index, rows[i].addr[17:8])
      `CHK(sector_index, rows[i].addr[17:12])
      `CHK(block_index, rows[i].addr[17:16])
    end
    settle(1);
    `CHK(erase_valid, 1'b0)
    op_start = 1'b1;
    settle(1);
    op_start = 1'b0;
    prog_byte = 1'b1;
    `CHK(prog_count, 9'h000)
    settle(255);
    `CHK(prog_room, 1'b1)
    settle(1);
    `CHK(prog_count, 9'h100)
    `CHK(prog_room, 1'b0)
    settle(1);
    prog_byte = 1'b0;
    `CHK(prog_count, 9'h100)
    for (int i = 0; i < 4; i++) begin
      {status_lock_bit, write_guard_n} = i[1:0];
      settle(5);
      `CHK(status_write_ok, 1'(i != 2))
    end
    cycle_busy = 1'b1;
    settle(5);
    `CHK(standby, 1'b0)
    cycle_busy = 1'b0;
    settle(5);
    `CHK(standby, 1'b1)
    host.xfer(8'hff, 8, 8, rxd);
    settle(12);
    `CHK(rx_valid, 1'b0)
    `CHK(serial_out_oe, 1'b0)
    host.open_frame(1'b0);
    settle(2);
    `CHK(standby, 1'b0)
    `CHK(spi_mode3, 1'b0)
    host.xfer(8'h3c, 8, 8, rxd);
    check_rx(sfb_rx_t'({1'b1, 8'h3c}));
    host.xfer(8'hc3, 8, 3, rxd);
    `CHK(rxd, 8'ha5)
    `CHK(host.pause_oe, 1'b0)
    check_rx(sfb_rx_t'({1'b0, 8'hc3}));
    host.close_frame();
    settle(6);
    `CHK(serial_out_oe, 1'b0)
    host.open_frame(1'b1);
    host.xfer(8'hff, 4, 8, rxd);
    host.close_frame();
    host.open_frame(1'b1);
    host.xfer(8'h96, 8, 8, rxd);
    check_rx(sfb_rx_t'({1'b1, 8'h96}));
    `CHK(spi_mode3, 1'b1)
    host.close_frame();
    settle(1);
    rx_ready = 1'b0;
    host.open_frame(1'b0);
    for (int i = 1; i < 4; i++) host.xfer(8'(i * 17), 8, 8, rxd);
    settle(10);
    `CHK(rx_overrun, 1'b0)
    host.xfer(8'h44, 8, 8, rxd);
    settle(10);
    `CHK(rx_overrun, 1'b1)
    rx_ready = 1'b1;
    check_rx(sfb_rx_t'({1'b1, 8'h11}));
    check_rx(sfb_rx_t'({1'b0, 8'h22}));
    check_rx(sfb_rx_t'({1'b0, 8'h33}));
    settle(4);
    `CHK(rx_valid, 1'b0)
    `CHK(tx_takes, 7)
    host.close_frame();
    give_verdict();
  end
endmodule : serial_flash_bus_front_end_test
`default_nettype wire
